// ==== design/phy_mgmt_pkg.sv ====
// constants for the per-port vendor management register bank
// assumes a 5-bit register address and 16-bit register data
package phy_mgmt_pkg;
  // register addresses
  localparam logic [4:0] ADDR_PARTNER_NEXT_PAGE_RX = 5'h08;
  localparam logic [4:0] ADDR_PORT_CONFIGURATION = 5'h10;
  localparam logic [4:0] ADDR_QUICK_STATUS = 5'h11;
  localparam logic [4:0] ADDR_INTERRUPT_MASK = 5'h12;
  localparam logic [4:0] ADDR_INTERRUPT_STATUS = 5'h13;
  localparam logic [4:0] ADDR_LED_CONFIGURATION = 5'h14;
  localparam logic [4:0] ADDR_TRANSMIT_SHAPING_ONE = 5'h1c;
  localparam logic [4:0] ADDR_TRANSMIT_SHAPING_TWO = 5'h1e;
  // reset values
  localparam logic [15:0] RST_PORT_CONFIGURATION = 16'h0080;
  localparam logic [15:0] RST_INTERRUPT_MASK = 16'h0000;
  localparam logic [15:0] RST_LED_CONFIGURATION = 16'h0422;
  localparam logic [15:0] RST_TRANSMIT_SHAPING = 16'h0000;
  // writable bits of each register
  localparam logic [15:0] WMASK_PORT_CONFIGURATION = 16'h7fa3;
  localparam logic [15:0] WMASK_INTERRUPT_MASK = 16'h00f3;
  localparam logic [15:0] WMASK_LED_CONFIGURATION = 16'hfffe;
  // port configuration bits
  localparam int CFG_FORCE_LINK = 14;
  localparam int CFG_TX_DISABLE = 13;
  localparam int CFG_SCRAMBLER_BYPASS = 12;
  localparam int CFG_BLOCK_CODE_BYPASS = 11;
  localparam int CFG_JABBER_DISABLE = 10;
  localparam int CFG_HEARTBEAT = 9;
  localparam int CFG_LOOPBACK_DISABLE = 8;
  localparam int CFG_CRS_SELECT = 7;
  localparam int CFG_PREAMBLE = 5;
  localparam int CFG_ALT_NEXT_PAGE = 1;
  localparam int CFG_FIBER = 0;
  // interrupt mask / status bits
  localparam int IRQ_NEGOTIATION = 7;
  localparam int IRQ_RATE = 6;
  localparam int IRQ_DUPLEX = 5;
  localparam int IRQ_LINK = 4;
  localparam int IRQ_GATE = 1;
  localparam int IRQ_TEST = 0;
  localparam int IRQ_PENDING = 2;
  // quick status bits
  localparam int QS_SPEED = 14;
  localparam int QS_TX = 13;
  localparam int QS_RX = 12;
  localparam int QS_COL = 11;
  localparam int QS_LINK = 10;
  localparam int QS_DUPLEX = 9;
  localparam int QS_NEG_MODE = 8;
  localparam int QS_NEG_DONE = 7;
  localparam int QS_POLARITY = 5;
  localparam int QS_PAUSE = 4;
  localparam int QS_ERROR = 3;
  // led configuration fields
  localparam int LED_SEL_W = 4;
  localparam int LED_COUNT = 3;
  localparam int LED1_LSB = 12;
  localparam int LED_FREQ_LSB = 2;
  localparam int LED_STRETCH_EN = 1;
  // led source codes
  localparam logic [3:0] LSRC_SPEED = 4'h0;
  localparam logic [3:0] LSRC_TX = 4'h1;
  localparam logic [3:0] LSRC_RX = 4'h2;
  localparam logic [3:0] LSRC_COL = 4'h3;
  localparam logic [3:0] LSRC_LINK = 4'h4;
  localparam logic [3:0] LSRC_DUPLEX = 4'h5;
  localparam logic [3:0] LSRC_ACTIVITY = 4'h7;
  localparam logic [3:0] LSRC_ON = 4'h8;
  localparam logic [3:0] LSRC_OFF = 4'h9;
  localparam logic [3:0] LSRC_FAST = 4'ha;
  localparam logic [3:0] LSRC_SLOW = 4'hb;
  localparam logic [3:0] LSRC_LINK_RX = 4'hc;
  localparam logic [3:0] LSRC_LINK_ACT = 4'hd;
  localparam logic [3:0] LSRC_DUPLEX_COL = 4'he;
  // stretch times and blink half periods
  localparam int CLK_MHZ = 250;
  localparam int STRETCH0_MS = 30;
  localparam int STRETCH1_MS = 60;
  localparam int STRETCH2_MS = 100;
  localparam int FAST_BLINK_MS = 100;
  localparam int SLOW_BLINK_MS = 500;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
endpackage

// ==== design/led_ctrl_if.sv ====
// led settings and shared time base between the bank and its led drivers
// assumes one clock domain
`timescale 1ns/1ns
`default_nettype none
interface led_ctrl_if;
  logic [1:0] durationSel;
  logic stretchEn;
  logic fastBlink;
  logic slowBlink;
  logic msTick;
  modport bank (output durationSel, output stretchEn, output fastBlink, output slowBlink,
    output msTick);
  modport led (input durationSel, input stretchEn, input fastBlink, input slowBlink,
    input msTick);
endinterface
`default_nettype wire

// ==== design/led_driver.sv ====
// one led output with source select and pulse stretch
// assumes status inputs already synchronised to clk_sys
`timescale 1ns/1ns
`default_nettype none
module led_driver (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEn,
  led_ctrl_if.led ctrl,
  input wire logic [3:0] sourceSel,
  input wire logic speedSt,
  input wire logic txSt,
  input wire logic rxSt,
  input wire logic colSt,
  input wire logic linkSt,
  input wire logic duplexSt,
  output logic ledOn
);
  logic [6:0] stretch_q;
  logic [3:0] sel_q;
  logic [6:0] limit;
  logic event_raw;
  logic combined;
  logic primary;
  logic stretched;
  logic level;

  // stretch length in ms from the duration code; reserved code keeps longest
  always_comb begin
    case (ctrl.durationSel)
      2'b00: limit = 7'(phy_mgmt_pkg::STRETCH0_MS);
      2'b01: limit = 7'(phy_mgmt_pkg::STRETCH1_MS);
      default: limit = 7'(phy_mgmt_pkg::STRETCH2_MS);
    endcase
  end

  // source selection; combined modes pair a primary level with an event
  always_comb begin
    event_raw = 1'b0;
    primary = 1'b0;
    combined = 1'b0;
    level = 1'b0;
    case (sourceSel)
      phy_mgmt_pkg::LSRC_SPEED: level = speedSt;
      phy_mgmt_pkg::LSRC_TX: event_raw = txSt;
      phy_mgmt_pkg::LSRC_RX: event_raw = rxSt;
      phy_mgmt_pkg::LSRC_COL: event_raw = colSt;
      phy_mgmt_pkg::LSRC_LINK: level = linkSt;
      phy_mgmt_pkg::LSRC_DUPLEX: level = duplexSt;
      phy_mgmt_pkg::LSRC_ACTIVITY: event_raw = txSt | rxSt;
      phy_mgmt_pkg::LSRC_ON: level = 1'b1;
      phy_mgmt_pkg::LSRC_OFF: level = 1'b0;
      phy_mgmt_pkg::LSRC_FAST: level = ctrl.fastBlink;
      phy_mgmt_pkg::LSRC_SLOW: level = ctrl.slowBlink;
      phy_mgmt_pkg::LSRC_LINK_RX: begin
        combined = 1'b1;
        primary = linkSt;
        event_raw = rxSt;
      end
      phy_mgmt_pkg::LSRC_LINK_ACT: begin
        combined = 1'b1;
        primary = linkSt;
        event_raw = txSt | rxSt;
      end
      phy_mgmt_pkg::LSRC_DUPLEX_COL: begin
        combined = 1'b1;
        primary = duplexSt;
        event_raw = colSt;
      end
      default: level = 1'b0;
    endcase
  end

  // last source selection, so a new selection can drop a stretch left from the old one
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sel_q <= '0;
    end else if (clkEn) begin
      sel_q <= sourceSel;
    end
  end

  // retrigger counter in ms ticks; an event reloads it, a source change empties it
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      stretch_q <= '0;
    end else if (clkEn) begin
      if (event_raw) begin
        stretch_q <= limit;
      end else if (sourceSel != sel_q) begin
        stretch_q <= '0;
      end else if (ctrl.msTick && stretch_q != '0) begin
        stretch_q <= stretch_q - 7'd1;
      end
    end
  end

  // an old stretch must not light a forced-off or level source after a reselect
  assign stretched = event_raw | (stretch_q != '0 && sourceSel == sel_q);

  // combined modes always stretch and blink against the primary level
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ledOn <= 1'b0;
    end else if (clkEn) begin
      if (combined) begin
        ledOn <= primary & ~(stretched & ctrl.fastBlink);
      end else if (ctrl.stretchEn) begin
        ledOn <= level | stretched;
      end else begin
        ledOn <= level | event_raw;
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/phy_port_vendor_mgmt_regs.sv ====
// per-port vendor management registers of a 10/100 transceiver port
// assumes a management serial frame decoder on clk_sys gives reg strobes;
// port status inputs arrive from other clock domains and are synchronised here
`timescale 1ns/1ns
`default_nettype none
module phy_port_vendor_mgmt_regs #(
  parameter int MS_CYCLES = phy_mgmt_pkg::CYC_PER_MS
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEn,
  // register access from the management frame decoder
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  // live port state from the physical layer
  input wire logic pageRxValid,
  input wire logic [15:0] pageRxWord,
  input wire logic speed100,
  input wire logic txActive,
  input wire logic rxActive,
  input wire logic colActive,
  input wire logic linkUp,
  input wire logic fullDuplex,
  input wire logic negEnabled,
  input wire logic negComplete,
  input wire logic polarityRev,
  input wire logic partnerPause,
  input wire logic remoteFault,
  // controls toward the physical layer
  output logic forceLinkPass,
  output logic txDisable,
  output logic scramblerBypass,
  output logic blockCodeBypass,
  output logic jabberDisable,
  output logic heartbeatEnable,
  output logic loopbackDisable,
  output logic crsExtend,
  output logic preambleEnable,
  output logic altNextPage,
  output logic fiberMode,
  output logic [15:0] shapingOne,
  output logic [15:0] shapingTwo,
  output logic management_irq_pin,
  output logic [2:0] ledOut
);
  localparam int NSTAT = 13;
  logic [NSTAT-1:0] statSync1_q;
  logic [NSTAT-1:0] statSync2_q;
  logic [NSTAT-1:0] statIn;
  logic [15:0] partner_next_page_rx_q;
  logic [15:0] port_configuration_q;
  logic [15:0] interrupt_mask_q;
  logic [15:0] led_configuration_q;
  logic [15:0] shapingOne_q;
  logic [15:0] shapingTwo_q;
  logic negotiation_done_flag_q;
  logic rate_changed_flag_q;
  logic duplex_changed_flag_q;
  logic link_changed_flag_q;
  logic prevSpeed_q;
  logic prevDuplex_q;
  logic prevLink_q;
  logic prevNeg_q;
  logic pagePrev_q;
  logic [31:0] msCount_q;
  logic msTick_q;
  logic [8:0] blinkCount_q;
  logic fastBlink_q;
  logic slowBlink_q;
  logic [2:0] slowDiv_q;
  logic sSpeed, sTx, sRx, sCol, sLink, sDuplex, sNegEn, sNegDone;
  logic sPol, sPause, sFault, sPageValid;
  logic effLink;
  logic statusRead;
  logic pendingAny;
  logic [15:0] quickStatus;
  logic [15:0] intStatus;
  logic [15:0] rdata_d;

  // two-stage synchronisers for everything that comes from the port domains except the page word
  assign statIn = {pageRxValid, speed100, txActive, rxActive, colActive, linkUp, fullDuplex,
    negEnabled, negComplete, polarityRev, partnerPause, remoteFault, 1'b0};
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      statSync1_q <= '0;
      statSync2_q <= '0;
    end else if (clkEn) begin
      statSync1_q <= statIn;
      statSync2_q <= statSync1_q;
    end
  end
  assign {sPageValid, sSpeed, sTx, sRx, sCol, sLink, sDuplex, sNegEn, sNegDone, sPol, sPause,
    sFault} = statSync2_q[NSTAT-1:1];

  // forced link reports the link as passing everywhere downstream
  assign effLink = sLink | port_configuration_q[phy_mgmt_pkg::CFG_FORCE_LINK];
  assign statusRead = regRead && regAddr == phy_mgmt_pkg::ADDR_INTERRUPT_STATUS;

  // partner next page captured on the rising edge of the page strobe; the word
  // is held stable by the port while the strobe is high, so it is safe to take
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pagePrev_q <= 1'b0;
      partner_next_page_rx_q <= '0;
    end else if (clkEn) begin
      pagePrev_q <= sPageValid;
      if (sPageValid && !pagePrev_q) begin
        partner_next_page_rx_q <= pageRxWord;
      end
    end
  end

  // writable registers; reserved bits stay zero through the write masks
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      port_configuration_q <= phy_mgmt_pkg::RST_PORT_CONFIGURATION;
      interrupt_mask_q <= phy_mgmt_pkg::RST_INTERRUPT_MASK;
      led_configuration_q <= phy_mgmt_pkg::RST_LED_CONFIGURATION;
      shapingOne_q <= phy_mgmt_pkg::RST_TRANSMIT_SHAPING;
      shapingTwo_q <= phy_mgmt_pkg::RST_TRANSMIT_SHAPING;
    end else if (clkEn && regWrite) begin
      case (regAddr)
        phy_mgmt_pkg::ADDR_PORT_CONFIGURATION:
          port_configuration_q <= regWdata & phy_mgmt_pkg::WMASK_PORT_CONFIGURATION;
        phy_mgmt_pkg::ADDR_INTERRUPT_MASK:
          interrupt_mask_q <= regWdata & phy_mgmt_pkg::WMASK_INTERRUPT_MASK;
        phy_mgmt_pkg::ADDR_LED_CONFIGURATION:
          led_configuration_q <= regWdata & phy_mgmt_pkg::WMASK_LED_CONFIGURATION;
        phy_mgmt_pkg::ADDR_TRANSMIT_SHAPING_ONE: shapingOne_q <= regWdata;
        phy_mgmt_pkg::ADDR_TRANSMIT_SHAPING_TWO: shapingTwo_q <= regWdata;
        default: ;
      endcase
    end
  end

  // change detection; a change in the read cycle sets the flag again so it is not lost
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prevSpeed_q <= 1'b0;
      prevDuplex_q <= 1'b0;
      prevLink_q <= 1'b0;
      prevNeg_q <= 1'b0;
      negotiation_done_flag_q <= 1'b0;
      rate_changed_flag_q <= 1'b0;
      duplex_changed_flag_q <= 1'b0;
      link_changed_flag_q <= 1'b0;
    end else if (clkEn) begin
      prevSpeed_q <= sSpeed;
      prevDuplex_q <= sDuplex;
      prevLink_q <= effLink;
      prevNeg_q <= sNegDone;
      negotiation_done_flag_q <= (sNegDone && !prevNeg_q) ||
        (negotiation_done_flag_q && !statusRead);
      rate_changed_flag_q <= (sSpeed != prevSpeed_q) ||
        (rate_changed_flag_q && !statusRead);
      duplex_changed_flag_q <= (sDuplex != prevDuplex_q) ||
        (duplex_changed_flag_q && !statusRead);
      link_changed_flag_q <= (effLink != prevLink_q) ||
        (link_changed_flag_q && !statusRead);
    end
  end

  // each event only counts toward the pin when its mask bit is set
  assign pendingAny = interrupt_mask_q[phy_mgmt_pkg::IRQ_GATE] &&
    ((negotiation_done_flag_q && interrupt_mask_q[phy_mgmt_pkg::IRQ_NEGOTIATION]) ||
     (rate_changed_flag_q && interrupt_mask_q[phy_mgmt_pkg::IRQ_RATE]) ||
     (duplex_changed_flag_q && interrupt_mask_q[phy_mgmt_pkg::IRQ_DUPLEX]) ||
     (link_changed_flag_q && interrupt_mask_q[phy_mgmt_pkg::IRQ_LINK]));

  // interrupt pin, active high, registered
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      management_irq_pin <= 1'b0;
    end else if (clkEn) begin
      management_irq_pin <= pendingAny ||
        interrupt_mask_q[phy_mgmt_pkg::IRQ_TEST];
    end
  end

  // live status view
  always_comb begin
    quickStatus = '0;
    quickStatus[phy_mgmt_pkg::QS_SPEED] = sSpeed;
    quickStatus[phy_mgmt_pkg::QS_TX] = sTx;
    quickStatus[phy_mgmt_pkg::QS_RX] = sRx;
    quickStatus[phy_mgmt_pkg::QS_COL] = sCol;
    quickStatus[phy_mgmt_pkg::QS_LINK] = effLink;
    quickStatus[phy_mgmt_pkg::QS_DUPLEX] = sDuplex;
    quickStatus[phy_mgmt_pkg::QS_NEG_MODE] = sNegEn;
    quickStatus[phy_mgmt_pkg::QS_NEG_DONE] = sNegDone;
    quickStatus[phy_mgmt_pkg::QS_POLARITY] = sPol;
    quickStatus[phy_mgmt_pkg::QS_PAUSE] = sPause;
    quickStatus[phy_mgmt_pkg::QS_ERROR] = sFault;
    intStatus = '0;
    intStatus[phy_mgmt_pkg::IRQ_NEGOTIATION] = negotiation_done_flag_q;
    intStatus[phy_mgmt_pkg::IRQ_RATE] = rate_changed_flag_q;
    intStatus[phy_mgmt_pkg::IRQ_DUPLEX] = duplex_changed_flag_q;
    intStatus[phy_mgmt_pkg::IRQ_LINK] = link_changed_flag_q;
    intStatus[phy_mgmt_pkg::IRQ_PENDING] = pendingAny;
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    case (regAddr)
      phy_mgmt_pkg::ADDR_PARTNER_NEXT_PAGE_RX: rdata_d = partner_next_page_rx_q;
      phy_mgmt_pkg::ADDR_PORT_CONFIGURATION: rdata_d = port_configuration_q;
      phy_mgmt_pkg::ADDR_QUICK_STATUS: rdata_d = quickStatus;
      phy_mgmt_pkg::ADDR_INTERRUPT_MASK: rdata_d = interrupt_mask_q;
      phy_mgmt_pkg::ADDR_INTERRUPT_STATUS: rdata_d = intStatus;
      phy_mgmt_pkg::ADDR_LED_CONFIGURATION: rdata_d = led_configuration_q;
      phy_mgmt_pkg::ADDR_TRANSMIT_SHAPING_ONE: rdata_d = shapingOne_q;
      phy_mgmt_pkg::ADDR_TRANSMIT_SHAPING_TWO: rdata_d = shapingTwo_q;
      default: rdata_d = '0;
    endcase
  end

  // read data is captured with the read strobe and held until the next read
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      regRdata <= '0;
    end else if (clkEn && regRead) begin
      regRdata <= rdata_d;
    end
  end

  // configuration outputs, registered so the port sees clean levels
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      forceLinkPass <= 1'b0;
      txDisable <= 1'b0;
      scramblerBypass <= 1'b0;
      blockCodeBypass <= 1'b0;
      jabberDisable <= 1'b0;
      heartbeatEnable <= 1'b0;
      loopbackDisable <= 1'b0;
      crsExtend <= 1'b1;
      preambleEnable <= 1'b0;
      altNextPage <= 1'b0;
      fiberMode <= 1'b0;
      shapingOne <= '0;
      shapingTwo <= '0;
    end else if (clkEn) begin
      forceLinkPass <= port_configuration_q[phy_mgmt_pkg::CFG_FORCE_LINK];
      txDisable <= port_configuration_q[phy_mgmt_pkg::CFG_TX_DISABLE];
      scramblerBypass <= port_configuration_q[phy_mgmt_pkg::CFG_SCRAMBLER_BYPASS];
      blockCodeBypass <= port_configuration_q[phy_mgmt_pkg::CFG_BLOCK_CODE_BYPASS];
      jabberDisable <= port_configuration_q[phy_mgmt_pkg::CFG_JABBER_DISABLE];
      heartbeatEnable <= port_configuration_q[phy_mgmt_pkg::CFG_HEARTBEAT];
      loopbackDisable <= port_configuration_q[phy_mgmt_pkg::CFG_LOOPBACK_DISABLE];
      crsExtend <= port_configuration_q[phy_mgmt_pkg::CFG_CRS_SELECT];
      preambleEnable <= port_configuration_q[phy_mgmt_pkg::CFG_PREAMBLE];
      altNextPage <= port_configuration_q[phy_mgmt_pkg::CFG_ALT_NEXT_PAGE];
      fiberMode <= port_configuration_q[phy_mgmt_pkg::CFG_FIBER];
      shapingOne <= shapingOne_q;
      shapingTwo <= shapingTwo_q;
    end
  end

  // millisecond tick and blink time base shared by the three leds
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      msCount_q <= '0;
      msTick_q <= 1'b0;
      blinkCount_q <= '0;
      fastBlink_q <= 1'b0;
      slowBlink_q <= 1'b0;
      slowDiv_q <= '0;
    end else if (clkEn) begin
      msTick_q <= 1'b0;
      if (msCount_q == 32'(MS_CYCLES - 1)) begin
        msCount_q <= '0;
        msTick_q <= 1'b1;
      end else begin
        msCount_q <= msCount_q + 32'd1;
      end
      if (msTick_q) begin
        if (blinkCount_q == 9'(phy_mgmt_pkg::FAST_BLINK_MS - 1)) begin
          blinkCount_q <= '0;
          fastBlink_q <= ~fastBlink_q;
          if (slowDiv_q == 3'(phy_mgmt_pkg::SLOW_BLINK_MS / phy_mgmt_pkg::FAST_BLINK_MS - 1)) begin
            slowDiv_q <= '0;
            slowBlink_q <= ~slowBlink_q;
          end else begin
            slowDiv_q <= slowDiv_q + 3'd1;
          end
        end else begin
          blinkCount_q <= blinkCount_q + 9'd1;
        end
      end
    end
  end

  led_ctrl_if ledBus ();
  assign ledBus.durationSel = led_configuration_q[phy_mgmt_pkg::LED_FREQ_LSB +: 2];
  assign ledBus.stretchEn = led_configuration_q[phy_mgmt_pkg::LED_STRETCH_EN];
  assign ledBus.fastBlink = fastBlink_q;
  assign ledBus.slowBlink = slowBlink_q;
  assign ledBus.msTick = msTick_q;

  // one driver per led, selector fields from the top of the register down
  for (genvar i = 0; i < phy_mgmt_pkg::LED_COUNT; i++) begin : gLed
    led_driver uLed (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .ctrl(ledBus.led),
      .sourceSel(led_configuration_q[phy_mgmt_pkg::LED1_LSB - i * phy_mgmt_pkg::LED_SEL_W +:
        phy_mgmt_pkg::LED_SEL_W]),
      .speedSt(sSpeed),
      .txSt(sTx),
      .rxSt(sRx),
      .colSt(sCol),
      .linkSt(effLink),
      .duplexSt(sDuplex),
      .ledOn(ledOut[i])
    );
  end
endmodule
`default_nettype wire

// ==== verif/mgmt_chk.sv ====
// port assertions for the vendor management bank
// assumes clkEn high and strobes driven one cycle wide
`timescale 1ns/1ns
`default_nettype none
module mgmt_chk (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic regWrite,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic forceLinkPass,
  input wire logic txDisable,
  input wire logic heartbeatEnable,
  input wire logic crsExtend,
  input wire logic fiberMode,
  input wire logic management_irq_pin,
  input wire logic [2:0] ledOut
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire logic cfgWr;
  wire logic maskWr;
  wire logic ledWr;
  // decoded write strobes; controls land two edges after the strobe
  assign cfgWr = regWrite && regAddr == 5'h10;
  assign maskWr = regWrite && regAddr == 5'h12;
  assign ledWr = regWrite && regAddr == 5'h14;
  a_force_link: assert property (cfgWr |-> ##2 forceLinkPass == $past(regWdata[14], 2))
    else $error("force link copy wrong");
  a_tx_disable: assert property (cfgWr |-> ##2 txDisable == $past(regWdata[13], 2))
    else $error("transmit disable copy wrong");
  a_heartbeat_copy: assert property (cfgWr |-> ##2 heartbeatEnable == $past(regWdata[9], 2))
    else $error("heartbeat enable copy wrong");
  a_fiber_copy: assert property (cfgWr |-> ##2 fiberMode == $past(regWdata[0], 2))
    else $error("fiber select copy wrong");
  a_crs_reset: assert property ($rose(reset_n) |-> crsExtend)
    else $error("carrier extend not set out of reset");
  a_gate_off: assert property (maskWr && regWdata[1:0] == 2'b00 |-> ##2 !management_irq_pin)
    else $error("interrupt with gate and test clear");
  a_test_irq: assert property (maskWr && regWdata[0] |-> ##2 management_irq_pin [*2])
    else $error("test interrupt not forced");
  a_led_force: assert property (ledWr && regWdata[15:12] == 4'h8 |-> ##2 ledOut[0])
    else $error("led forced on not lit");
  a_led_dark: assert property (ledWr && regWdata[15:12] == 4'h9 |-> ##2 !ledOut[0])
    else $error("led forced off still lit");
  c_test_irq: cover property (maskWr && regWdata[0]);
  c_led_write: cover property (ledWr);
  c_irq_rise: cover property ($rose(management_irq_pin));
endmodule
`default_nettype wire

// ==== verif/mgmt_ctrl_model.sv ====
// management controller model issuing one-cycle register strobes
// assumes read data is settled one cycle after the strobe edge
`timescale 1ns/1ns
`default_nettype none
module mgmt_ctrl_model (
  input wire logic clk_sys,
  output logic regWrite = 1'b0,
  output logic regRead = 1'b0,
  output logic [4:0] regAddr = 5'h00,
  output logic [15:0] regWdata = 16'h0000,
  input wire logic [15:0] regRdata
);
  // write; data is inverted once released so stale values never match
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clk_sys);
    regWrite = 1'b0;
    regWdata = ~d;
  endtask
  // read; data taken one cycle after the strobe edge
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk_sys);
    regRead = 1'b0;
    d = regRdata;
  endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the vendor management bank
// assumes a short millisecond count so stretch times stay brief
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic clkEn = 1'b1;
  logic pageRxValid = 1'b0;
  logic [15:0] pageRxWord = 16'h0000;
  logic [10:0] st = 11'h000;
  logic [15:0] d;
  int failures = 0;
  int numChecks = 0;
  wire logic regWrite, regRead, management_irq_pin;
  wire logic [4:0] regAddr;
  wire logic [15:0] regWdata, regRdata, shapingOne, shapingTwo;
  wire logic forceLinkPass, txDisable, scramblerBypass, blockCodeBypass, jabberDisable;
  wire logic heartbeatEnable, loopbackDisable, crsExtend, preambleEnable, altNextPage, fiberMode;
  wire logic [2:0] ledOut;
  wire logic speed100, txActive, rxActive, colActive, linkUp, fullDuplex, negEnabled;
  wire logic negComplete, polarityRev, partnerPause, remoteFault;
  wire logic [10:0] ctl;
  // status inputs packed so one assignment sets the whole port state
  assign {speed100, txActive, rxActive, colActive, linkUp, fullDuplex, negEnabled,
    negComplete, polarityRev, partnerPause, remoteFault} = st;
  assign ctl = {forceLinkPass, txDisable, scramblerBypass, blockCodeBypass, jabberDisable,
    heartbeatEnable, loopbackDisable, crsExtend, preambleEnable, altNextPage, fiberMode};
  always #2 clk_sys = ~clk_sys;
  phy_port_vendor_mgmt_regs #(.MS_CYCLES(10)) u_phy_port_vendor_mgmt_regs (.*);
  mgmt_ctrl_model u_mgmt_ctrl_model (.*);
  task automatic stop_test();
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic w(input logic [4:0] a, input logic [15:0] v);
    u_mgmt_ctrl_model.wr(a, v);
  endtask
  task automatic rc(input logic [4:0] a, input logic [15:0] exp);
    u_mgmt_ctrl_model.rd(a, d);
    chk(d, exp);
  endtask
  task automatic t_reset();
    rc(5'h10, 16'h0080);
    rc(5'h12, 16'h0000);
    rc(5'h14, 16'h0422);
    chk(16'(ctl), 16'h0008);
  endtask
  // all config bits set; reserved ones must read back clear
  task automatic t_cfg();
    w(5'h10, 16'hffff);
    rc(5'h10, 16'h7fa3);
    chk(16'(ctl), 16'h07ff);
    rc(5'h11, 16'h0400);
    w(5'h10, 16'h0000);
    cyc(2);
    chk(16'(ctl), 16'h0000);
    w(5'h1c, 16'h1234);
    w(5'h1e, 16'h8765);
    rc(5'h1c, 16'h1234);
    chk(shapingOne, 16'h1234);
    chk(shapingTwo, 16'h8765);
  endtask
  // a write to the page register is ignored, a received page lands
  task automatic t_page();
    w(5'h08, 16'hffff);
    rc(5'h08, 16'h0000);
    pageRxWord = 16'ha5c3;
    pageRxValid = 1'b1;
    cyc(6);
    rc(5'h08, 16'ha5c3);
  endtask
  task automatic t_status();
    st = 11'h7ff;
    cyc(4);
    rc(5'h11, 16'h7fb8);
    st = 11'h7f7;
    cyc(4);
    rc(5'h11, 16'h7f38);
  endtask
  // link event through mask and gate, then unmasked, ungated and test
  task automatic t_irq();
    u_mgmt_ctrl_model.rd(5'h13, d);
    w(5'h12, 16'h0012);
    st = 11'h7b7;
    cyc(6);
    chk(16'(management_irq_pin), 16'h1);
    rc(5'h13, 16'h0014);
    cyc(2);
    chk(16'(management_irq_pin), 16'h0);
    st = 11'h3b7;
    cyc(6);
    chk(16'(management_irq_pin), 16'h0);
    u_mgmt_ctrl_model.rd(5'h13, d);
    chk(d & 16'h0040, 16'h0040);
    w(5'h12, 16'h00f0);
    st = 11'h3f7;
    cyc(6);
    chk(16'(management_irq_pin), 16'h0);
    w(5'h12, 16'h0001);
    cyc(3);
    chk(16'(management_irq_pin), 16'h1);
    w(5'h12, 16'h0000);
  endtask
  task automatic pulse();
    st = 11'h200;
    cyc(4);
    st = 11'h000;
    cyc(20);
  endtask
  // stretch length per code, then raw events and a combined mode
  task automatic t_led();
    int dur[3] = '{300, 600, 1000};
    st = 11'h000;
    w(5'h14, 16'h8982);
    cyc(3);
    chk(16'(ledOut), 16'h0005);
    for (int c = 0; c < 3; c++) begin
      w(5'h14, 16'h1992 | 16'(c << 2));
      pulse();
      chk(16'(ledOut[0]), 16'h1);
      cyc(dur[c] - 60);
      chk(16'(ledOut[0]), 16'h1);
      cyc(100);
      chk(16'(ledOut[0]), 16'h0);
    end
    w(5'h14, 16'h1990);
    pulse();
    chk(16'(ledOut[0]), 16'h0);
    w(5'h14, 16'h9992);
    cyc(3);
    chk(16'(ledOut), 16'h0000);
    w(5'h14, 16'hc990);
    st = 11'h040;
    cyc(6);
    chk(16'(ledOut[0]), 16'h1);
  endtask
  initial begin
    cyc(12);
    reset_n = 1'b1;
    t_reset();
    t_cfg();
    t_page();
    t_status();
    t_irq();
    t_led();
    stop_test();
  end
  // hang guard, well past the few thousand cycles the tests need
  initial begin
    #60000;
    failures++;
    stop_test();
  end
endmodule
bind phy_port_vendor_mgmt_regs mgmt_chk u_mgmt_chk (.*);
`default_nettype wire
